// >>> include/ntb_pkg.sv
package ntb_pkg;
  // ----------------------------------------
  // config offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_STATUS   = 8'h04;
  localparam logic [7:0] OFS_CLASS    = 8'h08;
  localparam logic [7:0] OFS_MISC     = 8'h0c;
  localparam logic [7:0] OFS_WIN0     = 8'h10;
  localparam logic [7:0] OFS_IOWIN    = 8'h14;
  localparam logic [7:0] OFS_WIN1     = 8'h18;
  localparam logic [7:0] OFS_WIN2     = 8'h1c;
  localparam logic [7:0] OFS_WIN3     = 8'h20;
  localparam logic [7:0] OFS_WIN3_UP  = 8'h24;
  // ----------------------------------------
  // field positions and values
  // ----------------------------------------
  localparam int          SIG_TABORT_BIT = 27;
  localparam int          RCV_TABORT_BIT = 28;
  localparam int          RCV_MABORT_BIT = 29;
  localparam int          SIG_SERR_BIT   = 30;
  localparam int          DET_PERR_BIT   = 31;
  localparam int          SETUP_EN_BIT   = 31;
  localparam logic [7:0]  PROG_IF        = 8'h00;
  localparam logic [7:0]  SUB_CLASS      = 8'h80;
  localparam logic [7:0]  BASE_CLASS     = 8'h06;
  // arbitrary neutral revision value
  localparam logic [7:0]  REVISION       = 8'h01;
  localparam logic [7:0]  CLS_MASK       = 8'h3c;
  localparam logic [7:0]  CLS_RESET      = 8'h00;
  localparam logic [7:0]  LAT_RST_PCI    = 8'h00;
  localparam logic [7:0]  LAT_RST_PCIX   = 8'h40;
  localparam logic [7:0]  HDR_TYPE       = 8'h00;
  localparam logic [31:0] MEM_BASE_MASK  = 32'hfffff000;
  localparam logic [31:0] IO_BASE_MASK   = 32'hffffff00;
  localparam logic [31:0] WIN_RESET      = 32'h00000000;
  localparam logic [31:0] CSR_AREA_MASK  = 32'hfffff000;
  localparam logic [1:0]  ATYPE_32       = 2'b00;
  localparam logic [1:0]  ATYPE_64       = 2'b01;
endpackage

// >>> src/ntb_cfg_header.sv
`timescale 1ns/10ps
// Function
// [R1] bit 27 sets on completer abort sent or target abort signalled upstream.
// [R2] bit 28 sets on completer-abort completion or target abort received.
// [R3] bit 29 sets on unsupported-request completion or master abort detected.
// [R4] bit 30 sets on fatal/nonfatal message sent or system error driven.
// [R5] bit 31 sets on poisoned packet or primary parity error.
// [R6] status bits 27..31 clear by writing one; reset to zero.
// [R7] class code reads prog-if 00, sub-class 80, base class 06.
// [R8] cache line size bits 5:2 writable, others read zero.
// [R9] latency timer RO 00 forward; RW reverse, reset 00 PCI, 40 PCI-X.
// [R10] header type reads zero, single function, upper byte zero.
// [R11] first window 4KB..2GB; lowest 4KB maps registers, rest forwards.
// [R12] base bit writable only where its setup bit is one.
// [R13] first-window forwarded hits translate through its translated base.
// [R14] register I/O window reads I/O bit one, 256 bytes, base reset zero.
// [R15] second window memory or I/O per setup; translated base used.
// [R16] setup bit 31 zero disables the window; it claims nothing.
// [R17] third window 32-bit only, type 00, translated.
// [R18] fourth window: 32-bit translated, 64-bit untranslated with upper half.
// [R19] type bits read-only: space, address type, prefetch, 11:4 zero.
// [R20] read-only and reserved fields ignore writes, return fixed values.
module ntb_cfg_header (
  // clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_nrst,
  // mode straps
  input  wire logic        i_reverse_mode,
  input  wire logic        i_pcix_mode,
  // config access
  input  wire logic        i_cfg_wr,
  input  wire logic        i_cfg_rd,
  input  wire logic [7:0]  i_cfg_addr,
  input  wire logic [3:0]  i_cfg_be,
  input  wire logic [31:0] i_cfg_wdata,
  output logic      [31:0] o_cfg_rdata,
  // error events
  input  wire logic        i_ev_sig_tabort,
  input  wire logic        i_ev_rcv_tabort,
  input  wire logic        i_ev_rcv_mabort,
  input  wire logic        i_ev_sig_serr,
  input  wire logic        i_ev_det_perr,
  // setup registers of the windows
  input  wire logic [31:0] i_setup0,
  input  wire logic [31:0] i_setup_io,
  input  wire logic [31:0] i_setup1,
  input  wire logic [31:0] i_setup2,
  input  wire logic [31:0] i_setup3,
  input  wire logic [31:0] i_setup3_up,
  // translated bases
  input  wire logic [31:0] i_xlat0,
  input  wire logic [31:0] i_xlat1,
  input  wire logic [31:0] i_xlat2,
  input  wire logic [31:0] i_xlat3,
  // address decode request and result; system error pin
  input  wire logic [63:0] i_dec_addr,
  input  wire logic        i_dec_io,
  output logic             o_hit_csr_mem,
  output logic             o_hit_csr_io,
  output logic             o_hit_fwd,
  output logic      [63:0] o_fwd_addr,
  output logic             o_sys_err_n
);
  logic [4:0]  err_reg;
  logic [7:0]  cls_reg;
  logic [7:0]  lat_reg;
  logic [31:0] win0_reg;
  logic [31:0] iowin_reg;
  logic [31:0] win1_reg;
  logic [31:0] win2_reg;
  logic [31:0] win3_reg;
  logic [31:0] win3_up_reg;
  logic [31:0] wmask;
  logic [4:0]  err_next;
  logic        lat_init_reg;
  logic        hit_mem_next;
  logic        hit_io_next;
  logic        fwd_next;
  logic [63:0] fwd_addr_next;
  logic [31:0] win1_size_mask;
  logic [31:0] win0_wr_ok;
  logic [31:0] iowin_wr_ok;
  logic [31:0] win1_wr_ok;
  logic [31:0] win2_wr_ok;
  logic [31:0] win3_wr_ok;
  logic [31:0] win3_up_wr_ok;
  logic [31:0] win0_rd;
  logic [31:0] iowin_rd;
  logic [31:0] win1_rd;
  logic [31:0] win2_rd;
  logic [31:0] win3_rd;

  // ----------------------------------------
  // writable base bits per window
  // ----------------------------------------
  // low type bits never writable, so size probes read only the fixed or setup type bits there
  always_comb begin
    win1_size_mask = i_setup1[0] ? ntb_pkg::IO_BASE_MASK : ntb_pkg::MEM_BASE_MASK;
    win0_wr_ok     = i_setup0 & ntb_pkg::MEM_BASE_MASK; // R11
    iowin_wr_ok    = i_setup_io & ntb_pkg::IO_BASE_MASK; // R14
    win1_wr_ok     = i_setup1 & win1_size_mask; // R15
    win2_wr_ok     = i_setup2 & ntb_pkg::MEM_BASE_MASK; // R17
    win3_wr_ok     = i_setup3 & ntb_pkg::MEM_BASE_MASK; // R18
    win3_up_wr_ok  = i_setup3_up; // R18
  end

  // ----------------------------------------
  // write helpers
  // ----------------------------------------
  always_comb begin
    wmask = {{8{i_cfg_be[3]}}, {8{i_cfg_be[2]}}, {8{i_cfg_be[1]}}, {8{i_cfg_be[0]}}};
  end

  function automatic logic [31:0] upd(input logic [31:0] cur, input logic [31:0] wr_ok);
    logic [31:0] m;
    m = wr_ok & wmask;
    upd = (cur & ~m) | (i_cfg_wdata & m); // R12
  endfunction

  // ----------------------------------------
  // error status
  // ----------------------------------------
  always_comb begin
    err_next = err_reg;
    if (i_cfg_wr && i_cfg_addr == ntb_pkg::OFS_STATUS && i_cfg_be[3]) begin
      err_next = err_reg & ~i_cfg_wdata[31:27]; // R6
    end
    // set wins over a same-cycle clear
    err_next[0] = err_next[0] | i_ev_sig_tabort; // R1
    err_next[1] = err_next[1] | i_ev_rcv_tabort; // R2
    err_next[2] = err_next[2] | i_ev_rcv_mabort; // R3
    err_next[3] = err_next[3] | i_ev_sig_serr; // R4
    err_next[4] = err_next[4] | i_ev_det_perr; // R5
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      err_reg <= 5'h00; // R6
    end else begin
      err_reg <= err_next;
    end
  end

  // system error pin goes low one clock after its event, in reverse mode only
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_sys_err_n <= 1'b1;
    end else begin
      o_sys_err_n <= ~(i_reverse_mode & i_ev_sig_serr); // R4
    end
  end

  // ----------------------------------------
  // cache line size and latency timer
  // ----------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cls_reg <= ntb_pkg::CLS_RESET;
    end else if (i_cfg_wr && i_cfg_addr == ntb_pkg::OFS_MISC && i_cfg_be[0]) begin
      cls_reg <= i_cfg_wdata[7:0] & ntb_pkg::CLS_MASK; // R8
    end
  end

  // reset value depends on strap, so it is loaded on the first clock after release
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      lat_init_reg <= 1'b0;
      lat_reg      <= ntb_pkg::LAT_RST_PCI;
    end else begin
      lat_init_reg <= 1'b1;
      if (!lat_init_reg) begin
        lat_reg <= i_pcix_mode ? ntb_pkg::LAT_RST_PCIX : ntb_pkg::LAT_RST_PCI; // R9
      end else if (i_cfg_wr && i_cfg_addr == ntb_pkg::OFS_MISC && i_cfg_be[1]
                   && i_reverse_mode) begin
        lat_reg <= i_cfg_wdata[15:8]; // R9
      end
    end
  end

  // ----------------------------------------
  // base address windows
  // ----------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      win0_reg    <= ntb_pkg::WIN_RESET;
      iowin_reg   <= ntb_pkg::WIN_RESET;
      win1_reg    <= ntb_pkg::WIN_RESET;
      win2_reg    <= ntb_pkg::WIN_RESET;
      win3_reg    <= ntb_pkg::WIN_RESET;
      win3_up_reg <= ntb_pkg::WIN_RESET;
    end else if (i_cfg_wr) begin
      unique case (i_cfg_addr)
        ntb_pkg::OFS_WIN0: begin
          win0_reg <= upd(win0_reg, win0_wr_ok); // R11
        end
        ntb_pkg::OFS_IOWIN: begin
          iowin_reg <= upd(iowin_reg, iowin_wr_ok); // R14
        end
        ntb_pkg::OFS_WIN1: begin
          win1_reg <= upd(win1_reg, win1_wr_ok); // R15
        end
        ntb_pkg::OFS_WIN2: begin
          win2_reg <= upd(win2_reg, win2_wr_ok); // R17
        end
        ntb_pkg::OFS_WIN3: begin
          win3_reg <= upd(win3_reg, win3_wr_ok); // R18
        end
        ntb_pkg::OFS_WIN3_UP: begin
          win3_up_reg <= upd(win3_up_reg, win3_up_wr_ok); // R18
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  function automatic logic [31:0] bar_rd(input logic [31:0] base, input logic [31:0] setup,
                                         input logic [31:0] msk);
    bar_rd = (base & msk) | {28'h0000000, setup[3:0]}; // R19
  endfunction

  // ----------------------------------------
  // window read values
  // ----------------------------------------
  // win1..win3 type bits come from setup, never from the base flops; win0 and the I/O window read fixed ones
  always_comb begin
    win0_rd  = win0_reg & ntb_pkg::MEM_BASE_MASK; // R11
    iowin_rd = (iowin_reg & ntb_pkg::IO_BASE_MASK) | 32'h00000001; // R14
    win1_rd  = bar_rd(win1_reg, i_setup1 & 32'h0000000f, win1_size_mask); // R15
    win2_rd  = bar_rd(win2_reg, i_setup2 & 32'h00000008, ntb_pkg::MEM_BASE_MASK); // R17
    win3_rd  = bar_rd(win3_reg, i_setup3 & 32'h0000000a, ntb_pkg::MEM_BASE_MASK); // R18
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_cfg_rdata <= 32'h00000000;
    end else if (i_cfg_rd) begin
      unique case (i_cfg_addr)
        ntb_pkg::OFS_STATUS: o_cfg_rdata <= {err_reg, 27'h0000000};
        ntb_pkg::OFS_CLASS: begin
          o_cfg_rdata <= {ntb_pkg::BASE_CLASS, ntb_pkg::SUB_CLASS,
                          ntb_pkg::PROG_IF, ntb_pkg::REVISION}; // R7
        end
        ntb_pkg::OFS_MISC: begin
          o_cfg_rdata <= {8'h00, ntb_pkg::HDR_TYPE,
                          (i_reverse_mode ? lat_reg : 8'h00), cls_reg}; // R10
        end
        ntb_pkg::OFS_WIN0:    o_cfg_rdata <= win0_rd; // R11
        ntb_pkg::OFS_IOWIN:   o_cfg_rdata <= iowin_rd; // R14
        ntb_pkg::OFS_WIN1:    o_cfg_rdata <= win1_rd; // R15
        ntb_pkg::OFS_WIN2:    o_cfg_rdata <= win2_rd; // R17
        ntb_pkg::OFS_WIN3:    o_cfg_rdata <= win3_rd; // R18
        ntb_pkg::OFS_WIN3_UP: o_cfg_rdata <= win3_up_reg;
        default: o_cfg_rdata <= 32'h00000000; // R20
      endcase
    end
  end

  // ----------------------------------------
  // address decode and translation
  // ----------------------------------------
  function automatic logic hit32(input logic [31:0] a, input logic [31:0] base,
                                 input logic [31:0] setup, input logic [31:0] msk);
    logic [31:0] m;
    m = setup & msk;
    hit32 = setup[ntb_pkg::SETUP_EN_BIT] && ((a & m) == (base & m)); // R16
  endfunction

  always_comb begin
    logic [31:0] a;
    logic [31:0] m;
    a = i_dec_addr[31:0];
    m = 32'h00000000;
    hit_mem_next  = 1'b0;
    hit_io_next   = 1'b0;
    fwd_next      = 1'b0;
    fwd_addr_next = i_dec_addr;
    if (i_dec_io) begin
      if ((a & ntb_pkg::IO_BASE_MASK) == (iowin_reg & ntb_pkg::IO_BASE_MASK)) begin
        hit_io_next = 1'b1; // R14
      end else if (i_setup1[0] && hit32(a, win1_reg, i_setup1, ntb_pkg::IO_BASE_MASK)) begin
        m = i_setup1 & ntb_pkg::IO_BASE_MASK;
        fwd_next = 1'b1;
        fwd_addr_next = {32'h00000000, (i_xlat1 & m) | (a & ~m)}; // R15
      end
    end else if (i_dec_addr[63:32] == 32'h00000000
                 && hit32(a, win0_reg, i_setup0, ntb_pkg::MEM_BASE_MASK)) begin
      m = i_setup0 & ntb_pkg::MEM_BASE_MASK;
      if ((a & ~m & ntb_pkg::CSR_AREA_MASK) == 32'h00000000) begin
        hit_mem_next = 1'b1; // R11
      end else begin
        fwd_next = 1'b1;
        fwd_addr_next = {32'h00000000, (i_xlat0 & m) | (a & ~m)}; // R13
      end
    end else if (i_dec_addr[63:32] == 32'h00000000 && !i_setup1[0]
                 && hit32(a, win1_reg, i_setup1, ntb_pkg::MEM_BASE_MASK)) begin
      m = i_setup1 & ntb_pkg::MEM_BASE_MASK;
      fwd_next = 1'b1;
      fwd_addr_next = {32'h00000000, (i_xlat1 & m) | (a & ~m)}; // R15
    end else if (i_dec_addr[63:32] == 32'h00000000
                 && hit32(a, win2_reg, i_setup2, ntb_pkg::MEM_BASE_MASK)) begin
      m = i_setup2 & ntb_pkg::MEM_BASE_MASK;
      fwd_next = 1'b1;
      fwd_addr_next = {32'h00000000, (i_xlat2 & m) | (a & ~m)}; // R17
    end else if (i_setup3[2:1] == ntb_pkg::ATYPE_64) begin
      if (i_setup3[ntb_pkg::SETUP_EN_BIT] && i_setup3_up[ntb_pkg::SETUP_EN_BIT]
          && ((i_dec_addr & {i_setup3_up, i_setup3 & ntb_pkg::MEM_BASE_MASK})
              == ({win3_up_reg, win3_reg} & {i_setup3_up, i_setup3 & ntb_pkg::MEM_BASE_MASK}))) begin
        fwd_next = 1'b1; // R18
      end
    end else if (i_dec_addr[63:32] == 32'h00000000
                 && hit32(a, win3_reg, i_setup3, ntb_pkg::MEM_BASE_MASK)) begin
      m = i_setup3 & ntb_pkg::MEM_BASE_MASK;
      fwd_next = 1'b1;
      fwd_addr_next = {32'h00000000, (i_xlat3 & m) | (a & ~m)}; // R18
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_hit_csr_mem <= 1'b0;
      o_hit_csr_io  <= 1'b0;
      o_hit_fwd     <= 1'b0;
      o_fwd_addr    <= 64'h0000000000000000;
    end else begin
      o_hit_csr_mem <= hit_mem_next;
      o_hit_csr_io  <= hit_io_next;
      o_hit_fwd     <= fwd_next;
      o_fwd_addr    <= fwd_addr_next;
    end
  end
endmodule

// >>> tb/ntb_cfg_header_sva.sv
`timescale 1ns/10ps
module ntb_cfg_header_chk (
  // clock and reset
  input wire logic        i_sys_clk,
  input wire logic        i_nrst,
  // straps and requests
  input wire logic        i_reverse_mode,
  input wire logic        i_cfg_rd,
  input wire logic [7:0]  i_cfg_addr,
  input wire logic        i_ev_sig_serr,
  input wire logic [31:0] i_setup0,
  input wire logic [31:0] i_setup1,
  input wire logic [31:0] i_setup2,
  input wire logic [31:0] i_setup3,
  input wire logic        i_dec_io,
  // answers
  input wire logic [31:0] o_cfg_rdata,
  input wire logic        o_hit_csr_io,
  input wire logic        o_hit_fwd,
  input wire logic        o_sys_err_n
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  property p_serr; i_ev_sig_serr && i_reverse_mode |=> !o_sys_err_n; endproperty
  a_serr: assert property (p_serr) else $error("error pin not driven");
  property p_class; i_cfg_rd && i_cfg_addr == 8'h08 |=> o_cfg_rdata[31:8] == 24'h068000;
  endproperty
  a_class: assert property (p_class) else $error("class code wrong");
  property p_misc; i_cfg_rd && i_cfg_addr == 8'h0c |=>
    o_cfg_rdata[31:16] == 16'h0 && o_cfg_rdata[7:6] == 2'h0 && o_cfg_rdata[1:0] == 2'h0;
  endproperty
  a_misc: assert property (p_misc) else $error("fixed bits at 0c wrong");
  property p_lat; i_cfg_rd && i_cfg_addr == 8'h0c && !i_reverse_mode |=>
    o_cfg_rdata[15:8] == 8'h00; endproperty
  a_lat: assert property (p_lat) else $error("forward latency not zero");
  property p_iowin; i_cfg_rd && i_cfg_addr == 8'h14 |=> o_cfg_rdata[7:0] == 8'h01;
  endproperty
  a_iowin: assert property (p_iowin) else $error("io window type wrong");
  property p_stat; i_cfg_rd && i_cfg_addr == 8'h04 |=> o_cfg_rdata[26:0] == 27'h0;
  endproperty
  a_stat: assert property (p_stat) else $error("status low bits not zero");
  property p_iohit; o_hit_csr_io |-> $past(i_dec_io); endproperty
  a_iohit: assert property (p_iohit) else $error("io hit on memory request");
  property p_dis; !i_setup0[31] && !i_setup1[31] && !i_setup2[31] && !i_setup3[31]
    |=> !o_hit_fwd; endproperty
  a_dis: assert property (p_dis) else $error("disabled window forwarded");
endmodule
bind ntb_cfg_header ntb_cfg_header_chk u_chk (
  .i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_reverse_mode(i_reverse_mode),
  .i_cfg_rd(i_cfg_rd), .i_cfg_addr(i_cfg_addr), .i_ev_sig_serr(i_ev_sig_serr),
  .i_setup0(i_setup0), .i_setup1(i_setup1), .i_setup2(i_setup2), .i_setup3(i_setup3),
  .i_dec_io(i_dec_io), .o_cfg_rdata(o_cfg_rdata), .o_hit_csr_io(o_hit_csr_io),
  .o_hit_fwd(o_hit_fwd), .o_sys_err_n(o_sys_err_n)
);

// >>> tb/ntb_host_model.sv
`timescale 1ns/10ps
module ntb_host_model (
  // clock
  input  wire logic        i_sys_clk,
  // config requests
  output logic             o_wr,
  output logic             o_rd,
  output logic [7:0]       o_addr,
  output logic [3:0]       o_be,
  output logic [31:0]      o_wdata,
  // read return
  input  wire logic [31:0] i_rdata
);
  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 8'h00;
    o_be = 4'hf;
    o_wdata = 32'h0;
  end
  // released lines show the inverse so a stale copy is never trusted
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge i_sys_clk);
    #1;
    o_wr = w;
    o_rd = !w;
    o_addr = a;
    o_wdata = d;
    @(posedge i_sys_clk);
    #1;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = ~a;
    o_wdata = ~d;
    q = i_rdata;
  endtask
endmodule

// >>> tb/ntb_cfg_header_tb.sv
`timescale 1ns/10ps
module ntb_cfg_header_tb;
  logic        clk = 1'b0, nrst = 1'b0, rev = 1'b0, pcix = 1'b0, wr, rd;
  logic [7:0]  addr;
  logic [3:0]  be;
  logic [31:0] wdata, rdata, s0 = 32'h0, sio = 32'h0, s1 = 32'h0, s2 = 32'h0;
  logic [31:0] s3 = 32'h0, s3u = 32'h0, x0 = 32'h12340000, x2 = 32'h30000000;
  logic [4:0]  ev = 5'h00;
  logic [63:0] dec_a = 64'h0, fwd_a;
  logic        dec_io = 1'b0, hit_m, hit_io, hit_f, serr_n;
  int          mismatches = 0, n_compared = 0;
  always #5 clk = ~clk;
  ntb_cfg_header dut (
    .i_sys_clk(clk), .i_nrst(nrst), .i_reverse_mode(rev), .i_pcix_mode(pcix),
    .i_cfg_wr(wr), .i_cfg_rd(rd), .i_cfg_addr(addr), .i_cfg_be(be),
    .i_cfg_wdata(wdata), .o_cfg_rdata(rdata), .i_ev_sig_tabort(ev[0]),
    .i_ev_rcv_tabort(ev[1]), .i_ev_rcv_mabort(ev[2]), .i_ev_sig_serr(ev[3]),
    .i_ev_det_perr(ev[4]), .i_setup0(s0), .i_setup_io(sio), .i_setup1(s1),
    .i_setup2(s2), .i_setup3(s3), .i_setup3_up(s3u), .i_xlat0(x0), .i_xlat1(x0),
    .i_xlat2(x2), .i_xlat3(x2), .i_dec_addr(dec_a), .i_dec_io(dec_io),
    .o_hit_csr_mem(hit_m), .o_hit_csr_io(hit_io), .o_hit_fwd(hit_f),
    .o_fwd_addr(fwd_a), .o_sys_err_n(serr_n));
  ntb_host_model host (.i_sys_clk(clk), .o_wr(wr), .o_rd(rd), .o_addr(addr),
    .o_be(be), .o_wdata(wdata), .i_rdata(rdata));
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    host.xfer(1'b1, a, d, q);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    host.xfer(1'b0, a, 32'h0, q);
    chk({32'h0, q}, {32'h0, e});
  endtask
  task automatic rst(input logic r, input logic p);
    @(posedge clk);
    #1;
    rev = r;
    pcix = p;
    nrst = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    nrst = 1'b1;
    repeat (2) @(posedge clk);
  endtask
  // hits packed as csr memory, csr io, forward
  task automatic dec(input logic [63:0] a, input logic io, input logic [2:0] h,
                     input logic [63:0] ea);
    @(posedge clk);
    #1;
    dec_a = a;
    dec_io = io;
    @(posedge clk);
    #1;
    chk({61'h0, hit_m, hit_io, hit_f}, {61'h0, h});
    if (h[0]) chk(fwd_a, ea);
  endtask
  task automatic t_reset_vals();
    rdchk(8'h08, {ntb_pkg::BASE_CLASS, ntb_pkg::SUB_CLASS, 16'h0001});
    rdchk(8'h0c, 32'h0);
    rdchk(8'h14, 32'h1);
    rdchk(8'h04, 32'h0);
    rdchk(8'hfc, 32'h0);
    for (int i = 4; i < 10; i++) if (i != 5) rdchk(8'(i * 4), 32'h0);
  endtask
  task automatic t_status(input logic r);
    logic [31:0] b;
    rst(r, 1'b0);
    for (int i = 0; i < 5; i++) begin
      b = 32'h1 << (27 + i);
      @(posedge clk);
      #1;
      ev[i] = 1'b1;
      @(posedge clk);
      #1;
      ev[i] = 1'b0;
      chk({63'h0, serr_n}, {63'h0, !(r && i == 3)});
      rdchk(8'h04, b);
      wr_(8'h04, 32'h0);
      rdchk(8'h04, b);
      wr_(8'h04, b);
      rdchk(8'h04, 32'h0);
    end
  endtask
  task automatic t_misc();
    rst(1'b0, 1'b0);
    wr_(8'h0c, 32'hffffffff);
    rdchk(8'h0c, 32'h0000003c);
    rst(1'b1, 1'b1);
    rdchk(8'h0c, 32'h00004000);
    wr_(8'h0c, 32'hffffffff);
    rdchk(8'h0c, 32'h0000ff3c);
    rst(1'b1, 1'b0);
    rdchk(8'h0c, 32'h0);
  endtask
  task automatic t_windows();
    rst(1'b0, 1'b0);
    s0 = 32'hffffe000;
    sio = 32'hffffff00;
    s2 = 32'hfff00008;
    wr_(8'h10, 32'hffffffff);
    rdchk(8'h10, 32'hffffe000);
    wr_(8'h10, 32'h10000000);
    dec(64'h10000010, 1'b0, 3'b100, 64'h0);
    dec(64'h10001010, 1'b0, 3'b001, 64'h12341010);
    wr_(8'h14, 32'hffffffff);
    rdchk(8'h14, 32'hffffff01);
    wr_(8'h14, 32'h00000500);
    dec(64'h510, 1'b1, 3'b010, 64'h0);
    wr_(8'h1c, 32'hffffffff);
    rdchk(8'h1c, 32'hfff00008);
    wr_(8'h1c, 32'h20000000);
    dec(64'h20000040, 1'b0, 3'b001, 64'h30000040);
    s2 = 32'h7ff00008;
    dec(64'h20000040, 1'b0, 3'b000, 64'h0);
    // address type 01 sits in bits 2:1; upper setup bit 31 also enables
    s3 = 32'hfffff002;
    s3u = 32'h8000000f;
    wr_(8'h20, 32'hffffffff);
    rdchk(8'h20, 32'hfffff002);
    wr_(8'h24, 32'hffffffff);
    rdchk(8'h24, 32'h8000000f);
    wr_(8'h20, 32'h40000000);
    wr_(8'h24, 32'h1);
    dec(64'h0000000140000080, 1'b0, 3'b001, 64'h0000000140000080);
  endtask
  task automatic end_sim();
    if (mismatches == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    rst(1'b0, 1'b0);
    t_reset_vals();
    t_status(1'b0);
    t_status(1'b1);
    t_misc();
    t_windows();
    end_sim();
  end
  // the whole run needs a few hundred cycles
  initial begin
    #100000;
    mismatches++;
    end_sim();
  end
endmodule
